// >>> hw/scc_pkg.sv
// Constants, field layouts and carrier types of the serial port control block
package scc_pkg;

    // Register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_TXD  = 8'h0C;
    localparam logic [7:0] OFS_RXD  = 8'h10;

    // Control register field positions
    localparam int B_FSE  = 17;
    localparam int B_ENH  = 16;
    localparam int B_ON   = 15;
    localparam int B_IDLE_STOP = 13;
    localparam int B_DIS  = 12;
    localparam int B_WU   = 11;
    localparam int B_WL   = 10;
    localparam int B_SMP  = 9;
    localparam int B_CKE  = 8;
    localparam int B_SLAVE_SELECT_EN = 7;
    localparam int B_CKP  = 6;

    // Mode register field positions
    localparam int B_MST = 0;
    localparam int B_FRM = 1;
    localparam int B_AUD = 2;

    // Status register field positions
    localparam int B_BUSY = 0;
    localparam int B_RXF  = 1;
    localparam int B_HALT = 2;
    localparam int B_PEND = 3;
    localparam int B_BITS = 8;

    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] MODE_RST = 32'h0000_0000;
    localparam logic [31:0] DATA_RST = 32'h0000_0000;

    // Master bit clock: half period in ns, rounded up to clock cycles
    localparam int CLK_MHZ  = 100;
    localparam int HALF_NS  = 80;
    localparam int HALF_CYC = (HALF_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

    typedef struct packed {
        logic fse;
        logic enh;
        logic on;
        logic idle_stop;
        logic dis;
        logic wu;
        logic wl;
        logic sample_phase_sel;
        logic cke;
        logic slave_select_en;
        logic clock_polarity_sel;
    } scc_ctrl_s;

    typedef struct packed {
        logic aud;
        logic frm;
        logic mst;
    } scc_mode_s;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } scc_bus_s;

    typedef struct packed {
        logic sclk;
        logic sclk_oe;
        logic sdo;
        logic sdo_oe;
        logic fsync;
        logic ss_used;
        logic enh_buf;
    } scc_pins_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LEAD,
        ST_SHIFT
    } scc_state_e;

endpackage

// >>> hw/scc_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module scc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    // Asynchronous in, synchronous out
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            meta <= '0;
            q_o  <= '0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule // scc_sync

// >>> hw/scc_top.sv
// Serial port control bits with a minimal shift engine that obeys them
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module scc_top (
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               resetn_i,
    // Register port
    input  wire scc_pkg::scc_bus_s  bus_i,
    output logic [31:0]             rdata_o,
    // Device power state
    input  wire logic               idle_i,
    // Serial pins
    input  wire logic               sclk_i,
    input  wire logic               sdi_i,
    input  wire logic               ss_n_i,
    output scc_pkg::scc_pins_s      pins_o
);
    import scc_pkg::*;

    function automatic logic [5:0] data_bits_f(input scc_mode_s m,
                                               input scc_ctrl_s c);
        logic [5:0] r;
        r = 6'd16;
        if (m.aud) begin
            if (c.wu)
                r = c.wl ? 6'd24 : 6'd32;
        end else begin
            if (c.wu)
                r = 6'd32;
            else
                r = c.wl ? 6'd16 : 6'd8;
        end
        return r;
    endfunction

    function automatic logic [5:0] chan_bits_f(input scc_mode_s m,
                                               input scc_ctrl_s c);
        logic [5:0] r;
        r = data_bits_f(m, c);
        if (m.aud)
            r = c.wu ? 6'd32 : 6'd16;
        return r;
    endfunction

    function automatic logic [31:0] ctrl_word_f(input scc_ctrl_s c);
        logic [31:0] w;
        w         = 32'h0000_0000;
        w[B_FSE]  = c.fse;
        w[B_ENH]  = c.enh;
        w[B_ON]   = c.on;
        w[B_IDLE_STOP] = c.idle_stop;
        w[B_DIS]  = c.dis;
        w[B_WU]   = c.wu;
        w[B_WL]   = c.wl;
        w[B_SMP]  = c.sample_phase_sel;
        w[B_CKE]  = c.cke;
        w[B_SLAVE_SELECT_EN] = c.slave_select_en;
        w[B_CKP]  = c.clock_polarity_sel;
        return w;
    endfunction

    // Registers
    scc_ctrl_s   ctrl;
    scc_mode_s   mode;
    logic [31:0] tx_data;
    logic [31:0] rx_data;
    logic        rx_full;
    logic        tx_pend;

    // Engine state
    scc_state_e  state;
    logic [7:0]  timer;
    logic [6:0]  h;
    logic        lead_left;
    logic        mst_l;
    logic        o_l;
    logic        smp_l;
    logic [5:0]  bits;
    logic [5:0]  dbits;
    logic [5:0]  nsamp;
    logic [31:0] tx_shift;
    logic [31:0] rx_shift;
    logic        sclk_q;
    scc_pins_s   pins;

    // Synchronised pins
    logic [2:0]  pin_s;
    logic        sclk_s;
    logic        sdi_s;
    logic        ss_s;

    scc_sync #(.W(3)) u_sync (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .d_i      ({sclk_i, sdi_i, ss_n_i}),
        .q_o      (pin_s)
    );

    assign sclk_s = pin_s[2];
    assign sdi_s  = pin_s[1];
    assign ss_s   = pin_s[0];

    // Address decode
    wire wr_ctrl = bus_i.wr && (bus_i.addr == OFS_CTRL);
    wire wr_mode = bus_i.wr && (bus_i.addr == OFS_MODE);
    wire wr_tx   = bus_i.wr && (bus_i.addr == OFS_TXD);
    wire rd_rx   = bus_i.rd && (bus_i.addr == OFS_RXD);

    // Effective settings
    wire halted  = ctrl.idle_stop & idle_i;
    wire run     = ctrl.on & ~halted;
    wire pol     = mode.aud | ctrl.clock_polarity_sel;
    wire smp_eff = mode.mst & ctrl.sample_phase_sel;
    wire cke_eff = ~mode.frm & ctrl.cke;
    wire s_sel   = run & ~mode.mst & (~ctrl.slave_select_en | ~ss_s);
    wire [5:0] dbits_now = data_bits_f(mode, ctrl);
    wire [5:0] bits_now  = chan_bits_f(mode, ctrl);

    // Word is left aligned so the MSB leaves first; audio pads below data
    wire [31:0] tx_init = tx_data << (6'd32 - dbits_now);

    // Status and read mux
    logic [31:0] stat_word;
    always_comb begin
        stat_word                   = 32'h0000_0000;
        stat_word[B_BUSY]           = (state != ST_IDLE);
        stat_word[B_RXF]            = rx_full;
        stat_word[B_HALT]           = halted;
        stat_word[B_PEND]           = tx_pend;
        stat_word[B_BITS +: 6]      = bits_now;
    end

    wire [31:0] mode_word = {29'h0000_0000, mode.aud, mode.frm, mode.mst};
    wire [31:0] rd_word =
        (bus_i.addr == OFS_CTRL) ? ctrl_word_f(ctrl) :
        (bus_i.addr == OFS_MODE) ? mode_word :
        (bus_i.addr == OFS_STAT) ? stat_word :
        (bus_i.addr == OFS_TXD)  ? tx_data :
        (bus_i.addr == OFS_RXD)  ? rx_data : 32'h0000_0000;

    // Master timing
    wire tick    = (timer == HALF_LAST);
    wire m_step  = mst_l & tick & ((state == ST_SHIFT) ||
                   ((state == ST_LEAD) && !lead_left));
    wire [6:0] hn = (state == ST_LEAD) ? 7'h00 : h + 7'h01;
    wire [6:0] k  = hn - {6'h00, o_l};
    wire m_on    = (hn >= {6'h00, o_l});
    wire m_pres  = m_step & m_on & ~k[0] & (k[6:1] < bits);
    // End sampling takes the bit just before it changes
    wire m_samp  = m_step & m_on &
                   (k[0] ? ~smp_l : (smp_l & (k != 7'h00)));

    // Slave edges relative to the idle level
    wire s_lead  = (sclk_q == pol) && (sclk_s != pol);
    wire s_trail = (sclk_q != pol) && (sclk_s == pol);
    wire s_act   = ~mst_l & (state == ST_SHIFT);
    wire s_pres  = s_act & (o_l ? s_lead : s_trail) & (nsamp < bits);
    wire s_samp  = s_act & (o_l ? s_trail : s_lead);

    wire pres    = m_pres | s_pres;
    wire samp    = m_samp | s_samp;
    wire last    = samp && ((nsamp + 6'd1) == bits);
    wire start_m = (state == ST_IDLE) & run & mode.mst & tx_pend;
    wire start_s = (state == ST_IDLE) & s_sel;
    // Dropping enable, idle halt, a role change or deselect ends the word
    wire abort   = (state != ST_IDLE) &
                   (~run | (mode.mst != mst_l) | (~mst_l & ~s_sel));
    // A master word ends only once its clock is back at the idle level
    wire home    = ~mst_l | (hn >= {bits, 1'b0});
    wire done    = (last & home) |
                   (mst_l & m_step & (hn == {bits, 1'b0}) & (nsamp == bits));

    wire [31:0] rx_new   = {rx_shift[30:0], sdi_s};
    wire [31:0] rx_align = rx_new >> (bits - dbits);

    // Register writes
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ctrl    <= scc_ctrl_s'(CTRL_RST);
            mode    <= scc_mode_s'(MODE_RST);
            tx_data <= DATA_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl.fse  <= bus_i.wdata[B_FSE];
                ctrl.on   <= bus_i.wdata[B_ON];
                ctrl.idle_stop <= bus_i.wdata[B_IDLE_STOP];
                ctrl.dis  <= bus_i.wdata[B_DIS];
                ctrl.wu   <= bus_i.wdata[B_WU];
                ctrl.wl   <= bus_i.wdata[B_WL];
                ctrl.sample_phase_sel  <= bus_i.wdata[B_SMP];
                ctrl.cke  <= bus_i.wdata[B_CKE];
                ctrl.slave_select_en <= bus_i.wdata[B_SLAVE_SELECT_EN];
                ctrl.clock_polarity_sel  <= bus_i.wdata[B_CKP];
                if (!ctrl.on)
                    ctrl.enh <= bus_i.wdata[B_ENH];
            end
            if (wr_mode) begin
                mode.mst <= bus_i.wdata[B_MST];
                mode.frm <= bus_i.wdata[B_FRM];
                mode.aud <= bus_i.wdata[B_AUD];
            end
            if (wr_tx)
                tx_data <= bus_i.wdata;
        end
    end

    // Read data stands for one cycle only
    always_ff @(posedge clk_i) begin
        if (!resetn_i)
            rdata_o <= 32'h0000_0000;
        else
            rdata_o <= bus_i.rd ? rd_word : 32'h0000_0000;
    end

    // Flags: a new event wins over the clear
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            tx_pend <= 1'b0;
            rx_full <= 1'b0;
            rx_data <= DATA_RST;
        end else begin
            if (wr_tx)
                tx_pend <= 1'b1;
            else if (start_m)
                tx_pend <= 1'b0;
            if (last) begin
                rx_full <= 1'b1;
                rx_data <= rx_align;
            end else if (rd_rx) begin
                rx_full <= 1'b0;
            end
        end
    end

    // Half period timer for the master clock
    always_ff @(posedge clk_i) begin
        if (!resetn_i)
            timer <= 8'h00;
        else if (state == ST_IDLE || tick)
            timer <= 8'h00;
        else
            timer <= timer + 8'h01;
    end

    // Transfer sequencing
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state     <= ST_IDLE;
            h         <= 7'h00;
            lead_left <= 1'b0;
            mst_l     <= 1'b0;
            o_l       <= 1'b0;
            smp_l     <= 1'b0;
            bits      <= 6'd8;
            dbits     <= 6'd8;
        end else if (abort || done) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (start_m || start_s) begin
                        mst_l <= mode.mst;
                        o_l   <= ~cke_eff;
                        smp_l <= smp_eff;
                        bits  <= bits_now;
                        dbits <= dbits_now;
                        h     <= 7'h00;
                    end
                    if (start_m) begin
                        state     <= ST_LEAD;
                        lead_left <= mode.frm & ~ctrl.fse;
                    end else if (start_s) begin
                        state <= ST_SHIFT;
                    end
                end
                ST_LEAD: begin
                    if (tick && lead_left)
                        lead_left <= 1'b0;
                    else if (tick) begin
                        state <= ST_SHIFT;
                        h     <= hn;
                    end
                end
                ST_SHIFT: begin
                    if (m_step)
                        h <= hn;
                end
            endcase
        end
    end

    // Shift registers
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            tx_shift <= DATA_RST;
            rx_shift <= DATA_RST;
            nsamp    <= 6'd0;
            sclk_q   <= 1'b0;
        end else begin
            sclk_q <= sclk_s;
            if (start_m || start_s) begin
                rx_shift <= DATA_RST;
                nsamp    <= 6'd0;
                // Slave with late change must show its first bit at once
                tx_shift <= (start_s && cke_eff) ? tx_init << 1 : tx_init;
            end else begin
                if (pres)
                    tx_shift <= tx_shift << 1;
                if (samp) begin
                    rx_shift <= rx_new;
                    nsamp    <= nsamp + 6'd1;
                end
            end
        end
    end

    // Pin outputs, all registered
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            pins <= '0;
        end else begin
            pins.enh_buf <= ctrl.enh;
            pins.sclk_oe <= run & mode.mst;
            pins.sdo_oe  <= run & ~ctrl.dis & (mode.mst | s_sel);
            pins.ss_used <= run & ~mode.mst & ctrl.slave_select_en;
            if (start_s && cke_eff)
                pins.sdo <= tx_init[31];
            else if (pres)
                pins.sdo <= tx_shift[31];
            if (!run || !mode.mst || state == ST_IDLE || abort)
                pins.sclk <= pol;
            else if (m_step)
                pins.sclk <= (hn < {bits, 1'b0}) ? pol ^ hn[0] : pol;
            if (abort || !mode.frm || !mode.mst)
                pins.fsync <= 1'b0;
            else if (start_m)
                pins.fsync <= ~ctrl.fse;
            else if (m_step)
                pins.fsync <= ctrl.fse & (hn < 7'h02);
            else if (state == ST_IDLE)
                pins.fsync <= 1'b0;
        end
    end

    assign pins_o = pins;

endmodule // scc_top

// >>> sim/scc_asserts.sv
// Port-level assertions for the serial port control block
`timescale 1ns/1ps
module scc_asserts (
    // Clock and reset
    input wire logic              clk_i,
    input wire logic              resetn_i,
    // Register port
    input wire scc_pkg::scc_bus_s bus_i,
    input wire logic [31:0]       rdata_o,
    // Device state and pins
    input wire logic              idle_i,
    input wire logic              sclk_i,
    input wire logic              sdi_i,
    input wire logic              ss_n_i,
    input wire scc_pkg::scc_pins_s pins_o
);
    import scc_pkg::*;
    localparam logic [31:0] CTRL_MASK = 32'h0003_BFC0;
    logic [31:0] ctrl;
    logic [2:0]  mode;
    wire         on   = ctrl[B_ON];
    wire         halt = ctrl[B_IDLE_STOP] && idle_i;
    wire         run  = on && mode[B_MST] && !halt;
    // Shadow of the control word; enhanced bit frozen while the port is on
    wire  [31:0] next_ctrl = CTRL_MASK & {bus_i.wdata[31:17],
        on ? ctrl[B_ENH] : bus_i.wdata[B_ENH], bus_i.wdata[15:0]};

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ctrl <= 32'h0;
            mode <= 3'h0;
        end else if (bus_i.wr && bus_i.addr == OFS_CTRL) begin
            ctrl <= next_ctrl;
        end else if (bus_i.wr && bus_i.addr == OFS_MODE) begin
            mode <= bus_i.wdata[2:0];
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    a_ctrl_readback: assert property (
        bus_i.rd && bus_i.addr == OFS_CTRL |=> rdata_o == $past(ctrl))
        else $error("control readback mismatch");
    a_rdata_quiet: assert property (
        !$past(bus_i.rd) |-> rdata_o == 32'h0)
        else $error("read data outside read slot");
    a_bit14_zero: assert property (
        rdata_o[14] == 1'b0) else $error("bit 14 not zero");
    a_enh_follow: assert property (
        pins_o.enh_buf == $past(ctrl[B_ENH]))
        else $error("enhanced buffer flag wrong");
    a_sdo_release: assert property (
        $past(ctrl[B_DIS]) |-> !pins_o.sdo_oe)
        else $error("data pin driven while released");
    a_idle_halt: assert property (
        $past(halt) && $past(halt, 2) |-> !pins_o.sclk_oe && !pins_o.sdo_oe)
        else $error("pins driven while halted in idle");
    a_master_drives: assert property (
        $past(run) && $past(run, 2) |-> pins_o.sclk_oe)
        else $error("clock not driven while running");
    a_off_quiet: assert property (
        !$past(on) |-> !pins_o.sclk_oe && !pins_o.sdo_oe && !pins_o.ss_used)
        else $error("pins used while off");
    a_sclk_idle_level: assert property (
        $rose(pins_o.sclk_oe)
        |-> pins_o.sclk == ($past(ctrl[B_CKP]) | $past(mode[B_AUD])))
        else $error("clock idle level wrong");
    a_fsync_framed: assert property (
        pins_o.fsync |-> $past(mode[B_FRM] && mode[B_MST]))
        else $error("frame sync outside framed master");
    a_ss_claim: assert property (
        pins_o.ss_used |-> $past(ctrl[B_SLAVE_SELECT_EN] && !mode[B_MST]))
        else $error("select pin claimed wrongly");
endmodule // scc_asserts

bind scc_top scc_asserts chk_u (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .bus_i    (bus_i),
    .rdata_o  (rdata_o),
    .idle_i   (idle_i),
    .sclk_i   (sclk_i),
    .sdi_i    (sdi_i),
    .ss_n_i   (ss_n_i),
    .pins_o   (pins_o)
);

// >>> sim/scc_peer.sv
// Behavioural serial peripheral on the far side of the master link
`timescale 1ns/1ps
module scc_peer (
    // Clock and setup from the bench
    input  wire logic        clk_i,
    input  wire logic        clr_i,
    input  wire logic        pol_i,
    input  wire logic        cke_i,
    input  wire logic [5:0]  bits_i,
    input  wire logic [31:0] word_i,
    // Link pins
    input  wire logic        sclk_i,
    input  wire logic        sdo_i,
    output logic             sdi_o,
    // Observations
    output logic [31:0]      rx_o,
    output logic [5:0]       edges_o
);
    logic       sclk_q = 1'b0;
    logic       last   = 1'b0;
    logic [5:0] shown  = 6'h00;
    wire        edge_seen = sclk_i != sclk_q;
    wire        lead  = edge_seen && sclk_i != pol_i;
    wire        take  = edge_seen && lead == cke_i;
    wire  [5:0] idx   = cke_i ? shown : shown - 6'h01;
    wire  [5:0] pos   = bits_i - 6'h01 - idx;
    wire        act   = cke_i ? shown < bits_i
                              : shown != 6'h00 && shown <= bits_i;
    // Outside a word the line toggles so a stale bit is never sampled
    assign sdi_o = act ? word_i[pos[4:0]] : ~last;

    always @(posedge clk_i) begin
        sclk_q <= sclk_i;
        last <= sdi_o;
        if (clr_i) begin
            shown <= 6'h00;
            edges_o <= 6'h00;
            rx_o <= 32'h0;
        end else if (take) begin
            rx_o <= {rx_o[30:0], sdo_i};
            edges_o <= edges_o + 6'h01;
        end else if (edge_seen) begin
            shown <= shown + 6'h01;
        end
    end
endmodule // scc_peer

// >>> sim/scc_top_tb_top.sv
// Self-checking testbench for the serial port control block
`timescale 1ns/1ps
module scc_top_tb_top;
    import scc_pkg::*;
    // Same byte at both ends: the 8-bit word is the same either way aligned
    localparam logic [31:0] TXW = 32'hA5C3_96A5;
    localparam logic [31:0] PRW = 32'h3C5A_0FF1;
    logic        clk_i    = 1'b0;
    logic        resetn_i = 1'b0;
    logic        idle_i   = 1'b0;
    logic        clr      = 1'b1;
    logic        cke      = 1'b1;
    logic        pol      = 1'b0;
    logic        sck      = 1'b0;
    logic        ssn      = 1'b1;
    logic        slv      = 1'b0;
    logic [5:0]  bits     = 6'h08;
    logic        sdi;
    logic [5:0]  edges;
    logic [31:0] rdata, rx, d;
    scc_bus_s    bus      = '0;
    scc_pins_s   pins;
    int          num_errors = 0;
    int          checks     = 0;
    int          cyc        = 0;

    always #5 clk_i = ~clk_i;

    scc_top dut_u (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .bus_i    (bus),
        .rdata_o  (rdata),
        .idle_i   (idle_i),
        .sclk_i   (sck),
        .sdi_i    (sdi),
        .ss_n_i   (ssn),
        .pins_o   (pins)
    );
    scc_peer peer_u (
        .clk_i(clk_i), .clr_i(clr), .pol_i(pol), .cke_i(cke),
        .bits_i(bits), .word_i(PRW), .sclk_i(slv ? sck : pins.sclk),
        .sdo_i(pins.sdo), .sdi_o(sdi), .rx_o(rx), .edges_o(edges)
    );

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t pin %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus.rd <= 1'b0;
        @(negedge clk_i);
        d = rdata;
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic t_regs;
        rd(OFS_CTRL);
        chk32(d, CTRL_RST);
        wr(OFS_MODE, 32'h1); // master before sample phase
        wr(OFS_CTRL, 32'hFFFF_FFFF);
        rd(OFS_CTRL);
        chk32(d, 32'h0003_BFC0);
        chk1(pins.enh_buf, 1'b1);
        wr(OFS_CTRL, 32'h0); // enhanced bit stays set: the port was still on
        rd(OFS_CTRL);
        chk32(d, 32'h0001_0000);
        wr(OFS_CTRL, 32'h0);
        rd(OFS_CTRL);
        chk32(d, 32'h0);
        chk1(pins.enh_buf, 1'b0);
        rd(8'h40);
        chk32(d, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_pins;
        wr(OFS_CTRL, 32'h9000);
        settle(3);
        chk1(pins.sdo_oe, 1'b0);
        chk1(pins.sclk_oe, 1'b1);
        wr(OFS_CTRL, 32'h8000);
        settle(3);
        chk1(pins.sdo_oe, 1'b1);
        wr(OFS_MODE, 32'h0);
        wr(OFS_CTRL, 32'h8080);
        settle(3);
        chk1(pins.ss_used, 1'b1);
        wr(OFS_CTRL, 32'h8000);
        settle(3);
        chk1(pins.ss_used, 1'b0);
        wr(OFS_CTRL, 32'h0);
        $display("test pins done");
    endtask
    task automatic t_idle;
        wr(OFS_MODE, 32'h1);
        wr(OFS_CTRL, 32'hA000);
        @(posedge clk_i);
        idle_i <= 1'b1;
        settle(4);
        chk1(pins.sclk_oe, 1'b0);
        rd(OFS_STAT);
        chk32(d & 32'h4, 32'h4);
        wr(OFS_CTRL, 32'h8000);
        settle(4);
        chk1(pins.sclk_oe, 1'b1);
        @(posedge clk_i);
        idle_i <= 1'b0;
        wr(OFS_CTRL, 32'h0);
        settle(4);
        chk1(pins.sclk_oe, 1'b0);
        $display("test idle done");
    endtask
    task automatic t_xfer(input logic a, input logic [1:0] w, input logic ce,
                          input logic cp, input logic sp,
                          input logic [5:0] nb);
        logic [31:0] m;
        m = (nb == 6'h20) ? 32'hFFFF_FFFF : ~(32'hFFFF_FFFF << nb);
        cke = ce;
        pol = cp | a;
        bits = nb;
        wr(OFS_MODE, {29'h0, a, 2'b01}); // master before sample phase
        wr(OFS_CTRL, {16'h0, 1'b1, 3'h0, w, sp, ce, 1'b0, cp, 6'h0});
        settle(3);
        chk1(pins.sclk, cp | a);
        clr = 1'b0;
        wr(OFS_TXD, TXW);
        for (int i = 0; i < 1500 && edges !== nb; i++) @(negedge clk_i);
        settle(60);
        chk32({26'h0, edges}, {26'h0, nb});
        if (!a) begin
            chk32(rx & m, TXW & m);
            rd(OFS_RXD);
            chk32(d, PRW & m);
        end
        wr(OFS_CTRL, 32'h0);
        clr = 1'b1;
        $display("test xfer done");
    endtask
    task automatic t_frame(input logic fe);
        wr(OFS_MODE, 32'h3);
        wr(OFS_CTRL, {14'h0, fe, 17'h0_8000}); // clock edge kept 0
        settle(3);
        wr(OFS_TXD, TXW);
        settle(2);
        chk1(pins.fsync, ~fe);
        for (int i = 0; i < 400 && pins.sclk !== 1'b1; i++) @(negedge clk_i);
        chk1(pins.fsync, fe);
        settle(300);
        wr(OFS_CTRL, 32'h0);
        $display("test frame done");
    endtask
    task automatic t_slave;
        cke  = 1'b1;
        pol  = 1'b0;
        bits = 6'h08;
        slv  = 1'b1;
        wr(OFS_MODE, 32'h1); // master before sample phase
        wr(OFS_CTRL, 32'h8380);
        wr(OFS_MODE, 32'h0); // slave: sample phase must be ignored
        wr(OFS_TXD, TXW);
        settle(8);
        chk1(pins.sdo_oe, 1'b0);
        clr = 1'b0;
        @(posedge clk_i);
        ssn <= 1'b0;
        settle(8);
        chk1(pins.sdo_oe, 1'b1);
        repeat (16) begin
            repeat (8) @(posedge clk_i);
            sck <= ~sck;
        end
        settle(20);
        chk32({26'h0, edges}, 32'h0000_0008);
        chk32(rx & 32'hFF, TXW & 32'hFF);
        rd(OFS_RXD);
        chk32(d, PRW & 32'hFF);
        @(posedge clk_i);
        ssn <= 1'b1;
        wr(OFS_CTRL, 32'h0);
        clr = 1'b1;
        slv = 1'b0;
        $display("test slave done");
    endtask

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            report_and_stop;
        end
    end

    initial begin
        repeat (6) @(posedge clk_i);
        resetn_i <= 1'b1;
        t_regs;
        t_pins;
        t_idle;
        t_xfer(1'b0, 2'b00, 1'b1, 1'b0, 1'b0, 6'h08);
        t_xfer(1'b0, 2'b10, 1'b0, 1'b1, 1'b0, 6'h20);
        t_xfer(1'b0, 2'b11, 1'b1, 1'b0, 1'b1, 6'h20);
        t_xfer(1'b1, 2'b11, 1'b1, 1'b0, 1'b1, 6'h20);
        t_xfer(1'b1, 2'b10, 1'b0, 1'b0, 1'b1, 6'h20);
        t_xfer(1'b1, 2'b00, 1'b1, 1'b0, 1'b1, 6'h10);
        t_frame(1'b1);
        t_frame(1'b0);
        t_slave;
        report_and_stop;
    end
endmodule // scc_top_tb_top
